/* File: dv/wwbm_mux_tb.sv */
// Self-checking testbench of the wide word byte multiplexer.
module wwbm_mux_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [31:0] host_word_i = 32'h0;
  logic host_load_i = 1'b0;
  logic host_ready_o;
  logic [1:0] repeat_mode_i = 2'h0;
  logic [7:0] tx_byte_o;
  logic byte_send_strobe_o;
  int n_mismatch = 0;
  int tests_run = 0;
  int n_full = 0;
  always #50 clk_i = ~clk_i;
  wwbm_mux i_wwbm_mux (.clk_i(clk_i), .rst_n_i(rst_n_i), .host_word_i(host_word_i),
    .host_load_i(host_load_i), .host_ready_o(host_ready_o), .repeat_mode_i(repeat_mode_i),
    .tx_byte_o(tx_byte_o), .byte_send_strobe_o(byte_send_strobe_o));
  wwbm_tx_model i_wwbm_tx_model (.clk_i(clk_i), .byte_i(tx_byte_o), .strobe_i(byte_send_strobe_o));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Holds the load high until the word is taken; the caller releases it.
  task automatic push(input logic [31:0] w);
    int k;
    host_word_i = w;
    host_load_i = 1'b1;
    for (k = 0; k < 50 && host_ready_o !== 1'b1; k++) begin
      n_full++;
      tick(1);
    end
    check(host_ready_o, 1'b1);
    tick(1);
  endtask
  task automatic count_strobes(input int n, input int exp);
    int c;
    c = 0;
    repeat (n) begin
      tick(1);
      c += (byte_send_strobe_o === 1'b1);
    end
    check(c, exp);
  endtask
  task automatic t_reset();
    check(byte_send_strobe_o, 1'b0);
    check(tx_byte_o, 8'h00);
    check(host_ready_o, 1'b0);
    rst_n_i = 1'b1;
    count_strobes(10, 0);
    check(host_ready_o, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_fill();
    int i;
    int k;
    i_wwbm_tx_model.rx_q.delete();
    for (i = 0; i < 45; i++) push({4{i[7:0]}} ^ 32'h03020100);
    host_load_i = 1'b0;
    check(n_full > 0, 1'b1);
    count_strobes(20, 16);
    tick(200);
    check(i_wwbm_tx_model.rx_q.size(), 180);
    for (i = 0; i < 45; i++) for (k = 0; k < 4; k++) check(i_wwbm_tx_model.rx_q.pop_front(), i[7:0] ^ k[7:0]);
    $display("test fill and drain done");
  endtask
  task automatic t_word();
    int k;
    push(32'h44332211);
    host_load_i = 1'b0;
    tick(10);
    check(i_wwbm_tx_model.rx_q.size(), 4);
    for (k = 0; k < 4; k++) check(i_wwbm_tx_model.rx_q.pop_front(), 8'h11 * (k + 1));
    $display("test single word done");
  endtask
  task automatic t_modes();
    int s;
    repeat_mode_i = 2'h1;
    tick(10);
    s = i_wwbm_tx_model.n_sync;
    count_strobes(20, 20);
    check(i_wwbm_tx_model.n_sync - s, 0);
    repeat_mode_i = 2'h2;
    tick(12);
    s = i_wwbm_tx_model.n_sync;
    count_strobes(20, 16);
    check(i_wwbm_tx_model.n_sync - s, 4);
    repeat_mode_i = 2'h0;
    tick(10);
    count_strobes(10, 0);
    repeat_mode_i = 2'h3;
    tick(4);
    i_wwbm_tx_model.rx_q.delete();
    push(32'hA5B6C7D8);
    host_load_i = 1'b0;
    tick(10);
    check(i_wwbm_tx_model.rx_q.size(), 4);
    check(i_wwbm_tx_model.rx_q.pop_front(), 8'hD8);
    $display("test repeat modes done");
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    tick(2);
    t_reset();
    t_fill();
    t_word();
    t_modes();
    complete_run();
  end
  initial begin
    #1000000;
    n_mismatch++;
    complete_run();
  end
endmodule

/* File: dv/wwbm_tx_model.sv */
// Behavioural byte link transmitter that takes one byte per strobed clock.
module wwbm_tx_model (
  input wire logic clk_i,
  input wire logic [7:0] byte_i,
  input wire logic strobe_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rx_q[$];
  int n_sync = 0;
  // A clock without a strobe sends a sync symbol instead of a byte.
  always @(posedge clk_i) begin
    if (strobe_i === 1'b1) begin
      rx_q.push_back(byte_i);
    end else begin
      n_sync++;
    end
  end
endmodule

/* File: verilog/wwbm_fifo.sv */
// Parameterised valid/ready FIFO holding host words ahead of the multiplexer.
module wwbm_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic do_wr;
  logic do_rd;

  always_comb begin
    do_wr = in_valid_i && in_ready_o;
    do_rd = out_valid_o && out_ready_i;
    next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
    in_ready_o = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
    out_valid_o = (wr_ptr != rd_ptr);
    out_data_o = mem[rd_ptr[AW-1:0]];
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end
endmodule

/* File: verilog/wwbm_mux.sv */
// Top of the wide word byte multiplexer feeding a byte-wide link transmitter.
// What this block does
// - A load captures all byte lanes of the word together before any lane leaves.
// - A zero token shifts one stage per clock, selecting one lane in each of the four lane stages.
// - Outside continuous repeat, the first stage gate admits no new zero while lanes are still selected.
// - Selection and strobe settle at least half a cycle before the transmitter samples.
// - The byte strobe is asserted only in the cycle after a lane stage holds the token, repeat modes included.
// - An option feeds the fourth or fifth stage back instead of the load pulse.
// - Continuous repeat strobes the transmitter on every cycle, never leaving a sync.
// - Sync-gap repeat leaves exactly one unstrobed cycle after every four bytes.
// - Wide words go out through one byte transmitter, lane after lane.
module wwbm_mux (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [wwbm_pkg::WORD_W-1:0] host_word_i,
  input wire logic host_load_i,
  output logic host_ready_o,
  input wire logic [1:0] repeat_mode_i,
  output logic [wwbm_pkg::LANE_W-1:0] tx_byte_o,
  output logic byte_send_strobe_o
);
  logic [wwbm_pkg::WORD_W-1:0] f_data;
  logic f_valid;
  logic f_ready;
  logic f_in_ready;
  logic [1:0] mode_meta;
  logic [1:0] mode_sync;
  logic [wwbm_pkg::WORD_W-1:0] lane_buf;
  logic [wwbm_pkg::STAGES-1:0] stage;
  logic [wwbm_pkg::LANE_W-1:0] tx_byte;
  logic strobe;
  logic ready;
  logic [wwbm_pkg::WORD_W-1:0] next_lane_buf;
  logic [wwbm_pkg::STAGES-1:0] next_stage;
  logic [wwbm_pkg::LANE_W-1:0] next_tx_byte;
  logic next_strobe;
  logic busy;
  logic first_stage_input_gate;
  logic fourth_stage_output;
  logic fifth_stage_output;
  wwbm_pkg::wwbm_mode_t mode;
  localparam int CNT_W = $clog2(wwbm_pkg::FIFO_DEPTH) + 1;
  localparam logic [CNT_W-1:0] FIFO_FULL = CNT_W'(wwbm_pkg::FIFO_DEPTH);
  logic [CNT_W-1:0] fill;
  logic [CNT_W-1:0] next_fill;
  logic push;
  logic pop;
  logic idle;

  // Returns the lane picked by the one-cold token, or zero when no lane is enabled.
  function automatic logic [wwbm_pkg::LANE_W-1:0] pick_lane(input logic [wwbm_pkg::WORD_W-1:0] w,
                                                             input logic [wwbm_pkg::STAGES-1:0] s);
    logic [wwbm_pkg::LANE_W-1:0] r;
    r = '0;
    for (int i = 0; i < wwbm_pkg::LANES; i++) begin
      if (!s[i]) begin
        r = w[i*wwbm_pkg::LANE_W +: wwbm_pkg::LANE_W];
      end
    end
    return r;
  endfunction

  wwbm_fifo #(
    .WIDTH(wwbm_pkg::WORD_W),
    .DEPTH(wwbm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_data_i(host_word_i),
    .in_valid_i(host_load_i),
    .in_ready_o(f_in_ready),
    .out_data_o(f_data),
    .out_valid_o(f_valid),
    .out_ready_i(f_ready)
  );

  always_comb begin
    mode = wwbm_pkg::wwbm_mode_t'(mode_sync);
    fourth_stage_output = stage[wwbm_pkg::FOURTH_STAGE];
    fifth_stage_output = stage[wwbm_pkg::FIFTH_STAGE];
    busy = !(&stage[wwbm_pkg::LANES-1:0]);
    idle = &stage;
    f_ready = 1'b0;
    // Outside continuous repeat, the gate passes a zero only when no token is in the lane stages.
    // In a repeat mode an idle register restarts by itself, with no host load needed.
    case (mode)
      // Continuous repeat restarts as the fourth lane leaves, so no gap appears.
      wwbm_pkg::WWBM_MODE_REPEAT_CONT: first_stage_input_gate = fourth_stage_output && !idle;
      // Sync-gap repeat restarts from idle, or once the token sits in the fifth stage.
      wwbm_pkg::WWBM_MODE_REPEAT_SYNC: first_stage_input_gate = busy || (fifth_stage_output && !idle);
      // Code three lands here as well, so it runs as normal mode and pops the FIFO.
      default: begin
        first_stage_input_gate = busy || !f_valid;
        f_ready = !first_stage_input_gate;
      end
    endcase
    // Token enters stage 0 and walks one stage per clock.
    next_stage = {stage[wwbm_pkg::STAGES-2:0], first_stage_input_gate};
    // All lanes are captured at once on the load, before the first lane is sent.
    next_lane_buf = (!first_stage_input_gate && f_ready) ? f_data : lane_buf;
    // One byte lane goes to the single transmitter per stage.
    next_tx_byte = pick_lane(lane_buf, stage);
    // Strobe only while a lane stage holds the token.
    next_strobe = busy;
    push = host_load_i && f_in_ready;
    pop = f_valid && f_ready;
    next_fill = fill + CNT_W'(push) - CNT_W'(pop);
    // Ready looks one edge ahead, so a registered high always means a free slot.
    ready = (next_fill != FIFO_FULL);
  end

  // Registered on the same edge; outputs settle a full cycle before sampling.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage <= wwbm_pkg::STAGES_IDLE;
      lane_buf <= '0;
      tx_byte <= '0;
      strobe <= 1'b0;
      fill <= '0;
      mode_meta <= '0;
      mode_sync <= '0;
    end else begin
      stage <= next_stage;
      lane_buf <= next_lane_buf;
      tx_byte <= next_tx_byte;
      strobe <= next_strobe;
      fill <= next_fill;
      mode_meta <= repeat_mode_i;
      mode_sync <= mode_meta;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      host_ready_o <= 1'b0;
    end else begin
      host_ready_o <= ready;
    end
  end

  assign tx_byte_o = tx_byte;
  assign byte_send_strobe_o = strobe;

  // Checks on the token walk and on what reaches the transmitter.
  sequence s_token_in;
    !stage[0];
  endsequence

  sequence s_four_bytes;
    byte_send_strobe_o [*4];
  endsequence

  // The four lanes of the captured word leave in order, low byte first.
  sequence s_lane_order;
    tx_byte_o == $past(lane_buf[0 +: wwbm_pkg::LANE_W])
    ##1 tx_byte_o == $past(lane_buf[wwbm_pkg::LANE_W +: wwbm_pkg::LANE_W], 2)
    ##1 tx_byte_o == $past(lane_buf[2*wwbm_pkg::LANE_W +: wwbm_pkg::LANE_W], 3)
    ##1 tx_byte_o == $past(lane_buf[3*wwbm_pkg::LANE_W +: wwbm_pkg::LANE_W], 4);
  endsequence

  property p_one_token;
    @(posedge clk_i) disable iff (!rst_n_i) $countones(~stage[wwbm_pkg::LANES-1:0]) <= 1;
  endproperty
  a_one_token: assert property (p_one_token) else $error("More than one token in lanes.");

  property p_walk;
    @(posedge clk_i) disable iff (!rst_n_i) s_token_in |=> !stage[1] ##1 !stage[2] ##1 !stage[3];
  endproperty
  a_walk: assert property (p_walk) else $error("Token did not advance one stage per clock.");

  property p_strobe;
    @(posedge clk_i) disable iff (!rst_n_i) s_token_in |=> s_four_bytes;
  endproperty
  a_strobe: assert property (p_strobe) else $error("Four strobes did not follow the token.");

  property p_lanes;
    @(posedge clk_i) disable iff (!rst_n_i) s_token_in |=> s_lane_order;
  endproperty
  a_lanes: assert property (p_lanes) else $error("Lanes did not leave in order.");

  property p_quiet;
    @(posedge clk_i) disable iff (!rst_n_i) (&stage[wwbm_pkg::LANES-1:0]) |=> !byte_send_strobe_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("Strobe with no lane selected.");

  property p_no_reentry;
    @(posedge clk_i) disable iff (!rst_n_i) !(&stage[wwbm_pkg::LANES-2:0]) |=> stage[0];
  endproperty
  a_no_reentry: assert property (p_no_reentry) else $error("Zero entered while a lane was selected.");

  property p_capture;
    @(posedge clk_i) disable iff (!rst_n_i)
      (f_valid && f_ready) |=> !stage[0] && (lane_buf == $past(f_data));
  endproperty
  a_capture: assert property (p_capture) else $error("Word not captured whole as its token entered.");

  property p_restart;
    @(posedge clk_i) disable iff (!rst_n_i)
      (mode inside {wwbm_pkg::WWBM_MODE_REPEAT_CONT, wwbm_pkg::WWBM_MODE_REPEAT_SYNC}) && idle |=> !stage[0];
  endproperty
  a_restart: assert property (p_restart) else $error("Repeat mode did not restart from idle.");

  property p_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
      !(mode inside {wwbm_pkg::WWBM_MODE_REPEAT_CONT, wwbm_pkg::WWBM_MODE_REPEAT_SYNC}) && idle && !f_valid |=> stage[0];
  endproperty
  a_hold: assert property (p_hold) else $error("Token entered with no word waiting.");

  property p_cont;
    @(posedge clk_i) disable iff (!rst_n_i)
      (mode == wwbm_pkg::WWBM_MODE_REPEAT_CONT) [*8] |-> byte_send_strobe_o;
  endproperty
  a_cont: assert property (p_cont) else $error("Gap in continuous repeat.");

  property p_gap;
    @(posedge clk_i) disable iff (!rst_n_i)
      (mode == wwbm_pkg::WWBM_MODE_REPEAT_SYNC) [*8] ##0 $fell(byte_send_strobe_o)
      |=> $rose(byte_send_strobe_o) ##1 byte_send_strobe_o [*3];
  endproperty
  a_gap: assert property (p_gap) else $error("Sync gap not one cycle then four bytes.");
endmodule

/* File: verilog/wwbm_pkg.sv */
// Package with the constants and types of the wide word byte multiplexer.
package wwbm_pkg;
  localparam int WORD_W = 32;
  localparam int LANE_W = 8;
  localparam int LANES = WORD_W / LANE_W;
  localparam int STAGES = LANES + 1;
  localparam int FIFO_DEPTH = 32;
  localparam logic [STAGES-1:0] STAGES_IDLE = 5'h1F;
  localparam int FOURTH_STAGE = 3;
  localparam int FIFTH_STAGE = 4;
  typedef enum logic [1:0] {
    WWBM_MODE_NORMAL = 2'h0,
    WWBM_MODE_REPEAT_CONT = 2'h1,
    WWBM_MODE_REPEAT_SYNC = 2'h2
  } wwbm_mode_t;
endpackage
